// ==== hw/dsar_pkg.sv ====
// constants for the differential sar converter serial readout
package dsar_pkg;
  localparam int unsigned RES_BITS   = 14;
  localparam int unsigned NULL_BITS  = 2;
  localparam int unsigned FRAME_BITS = NULL_BITS + RES_BITS;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  CNT_RST    = 5'h00;
  localparam logic [13:0] RES_RST    = 14'h0000;
  // serial clock limits, kHz, and the 40 ns system clock period
  localparam int unsigned SYS_CLK_KHZ  = 25000;
  localparam int unsigned SCLK_MIN_KHZ = 900;
  localparam int unsigned SCLK_MAX_KHZ = 4500;
  // shortest sclk half period in system cycles, rounded down
  localparam int unsigned SCLK_HALF_MIN_CYC = SYS_CLK_KHZ / (2 * SCLK_MAX_KHZ);
  typedef enum logic [2:0] {
    DSAR_TRACK  = 3'b001,
    DSAR_CONV   = 3'b010,
    DSAR_HOLD   = 3'b100
  } dsar_state_t;
endpackage

// ==== hw/dsar_readout.sv ====
// serial conversion and readout logic of the differential sar converter
// Summary of operation
// - select falling edge starts a conversion
// - select high: track mode, no conversion
// - frame: two null bits, fourteen bits msb first
// - data changes on sclk fall, sampled rising
// - sclk alone steps the approximation
// - result is two's complement
// - frame carries its own conversion, no latency
`timescale 1ns/1ps
`default_nettype none
module dsar_readout
  import dsar_pkg::*;
#(
  parameter int unsigned RES_W = RES_BITS
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // serial link, sampled on sys_clk
  input  wire logic             cs_n,
  input  wire logic             sclk,
  output logic                  dout,
  // comparator from analog core: 1 when input above trial level
  input  wire logic             cmp_above,
  // analog core control
  output logic [RES_W-1:0]      dac_trial_q,
  output logic                  track_q,
  output logic                  busy_q,
  // finished result and its strobe
  output logic [RES_W-1:0]      result_q,
  output logic                  result_valid_q
);
  // frame control
  dsar_state_t      state_q;
  logic [CNT_W-1:0] cnt_q;

  // previous samples of the host pins
  logic             cs_n_q;
  logic             sclk_q;

  // approximation register and serial output
  logic [RES_W-1:0] sar_q;
  logic             dout_q;

  // decoded events
  logic             cs_fall;
  logic             sclk_fall;
  logic             conv_step;
  logic             bit_step;
  logic             last_step;
  logic [CNT_W-1:0] bit_idx;

  assign cs_fall   = cs_n_q && !cs_n;
  assign sclk_fall = sclk_q && !sclk && !cs_n;

  // one approximation step per falling sclk while converting
  assign conv_step = (state_q == DSAR_CONV) && sclk_fall;

  // steps after the two nulls decide one result bit each
  assign bit_step  = conv_step && (cnt_q >= CNT_W'(NULL_BITS));

  // the sixteenth fall decides the lsb and closes the frame
  assign last_step = conv_step && (cnt_q == CNT_W'(FRAME_BITS - 1));

  // msb index still being decided once nulls are out
  assign bit_idx   = CNT_W'(FRAME_BITS) - 5'h01 - cnt_q;

  // select history; idle high so no false start after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_n_q <= 1'b1;
    end else begin
      cs_n_q <= cs_n;
    end
  end

  // sclk history; a fall only counts while select is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // frame state: select high always returns to track, which aborts a cut frame
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= DSAR_TRACK;
    end else if (cs_n) begin
      state_q <= DSAR_TRACK;
    end else begin
      unique case (state_q)
        DSAR_TRACK: begin
          if (cs_fall) begin
            state_q <= DSAR_CONV;
          end
        end
        DSAR_CONV: begin
          if (last_step) begin
            state_q <= DSAR_HOLD;
          end
        end
        DSAR_HOLD: begin
          // extra sclk edges after the lsb are ignored
          state_q <= DSAR_HOLD;
        end
      endcase
    end
  end

  // falling sclk edge counter inside the frame
  always_ff @(posedge sys_clk) begin
    if (rst || cs_n || cs_fall) begin
      cnt_q <= CNT_RST;
    end else if (conv_step) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // successive approximation, one bit per sclk fall after the nulls.
  // the trial level is offset binary; msb inverted gives two's complement.
  for (genvar b = 0; b < RES_W; b++) begin : g_bit

    // decided bit b, cleared at every frame start
    always_ff @(posedge sys_clk) begin
      if (rst || cs_n || cs_fall) begin
        sar_q[b] <= RES_RST[b];
      end else if (bit_step && bit_idx == CNT_W'(b)) begin
        sar_q[b] <= cmp_above;
      end
    end

    // trial bit b: tried at one just after the bit above is decided
    always_ff @(posedge sys_clk) begin
      if (rst || cs_n) begin
        dac_trial_q[b] <= RES_RST[b];
      end else if (cs_fall) begin
        dac_trial_q[b] <= (b == RES_W - 1) ? 1'b1 : 1'b0;
      end else if (bit_step && bit_idx == CNT_W'(b)) begin
        dac_trial_q[b] <= cmp_above;
      end else if (bit_step && bit_idx == CNT_W'(b + 1)) begin
        dac_trial_q[b] <= 1'b1;
      end
    end

  end

  // serial out: nulls, then each bit as soon as it is decided.
  // no buffer: the bit leaves on the same fall that decides it.
  always_ff @(posedge sys_clk) begin
    if (rst || cs_n || cs_fall) begin
      dout_q <= 1'b0;
    end else if (conv_step) begin
      if (cnt_q < CNT_W'(NULL_BITS)) begin
        dout_q <= 1'b0;
      end else if (cnt_q == CNT_W'(NULL_BITS)) begin
        dout_q <= ~cmp_above;                         // sign bit
      end else begin
        dout_q <= cmp_above;
      end
    end
  end

  // result capture once the lsb is decided; a cut frame keeps the old one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_q <= RES_RST;
    end else if (last_step) begin
      result_q <= {~sar_q[RES_W-1], sar_q[RES_W-2:1], cmp_above};
    end
  end

  // one-cycle strobe beside the new result
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= last_step;
    end
  end

  // track mode follows select directly
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      track_q <= 1'b1;
    end else begin
      track_q <= cs_n;
    end
  end

  // busy from select low until the lsb is out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= !cs_n && state_q != DSAR_HOLD;
    end
  end

  // pin comes straight from its flip-flop
  assign dout = dout_q;

endmodule
`default_nettype wire

// ==== tb/dsar_readout_checker.sv ====
// port assertions for the sar readout
`timescale 1ns/1ps
`default_nettype none
module dsar_readout_checker #(parameter int unsigned RES_W = 14) (
  input wire logic sys_clk, rst, cs_n, sclk, dout, cmp_above, track_q, busy_q, result_valid_q,
  input wire logic [RES_W-1:0] dac_trial_q, result_q);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_track_idle: assert property (cs_n[*2] |=> track_q && !busy_q)
    else $error("idle");
  a_track_busy: assert property (track_q |-> !busy_q && !result_valid_q)
    else $error("trk");
  a_start_conv: assert property ($fell(cs_n) |=> busy_q && !track_q && dac_trial_q == 14'h2000)
    else $error("go");
  a_dout_idle: assert property (cs_n[*2] |=> !dout)
    else $error("dout");
  a_dout_fall: assert property ($changed(dout) && !$past(cs_n) |-> !$past(sclk))
    else $error("edge");
  a_valid_pulse: assert property (result_valid_q |-> busy_q ##1 !busy_q && !result_valid_q)
    else $error("pulse");
  a_valid_frame: assert property (result_valid_q |-> !cs_n)
    else $error("frame");
  a_result_upd: assert property ($changed(result_q) |-> result_valid_q)
    else $error("res");
  cover property ($fell(cs_n));
  cover property (result_valid_q);
  cover property (busy_q ##1 cs_n);
endmodule
bind dsar_readout dsar_readout_checker #(.RES_W(RES_W)) u_chk (.*);
`default_nettype wire

// ==== tb/dsar_host.sv ====
// serial controller model: frames, clocks and captures words
`timescale 1ns/1ps
`default_nettype none
module dsar_host (input wire logic sys_clk, dout, output logic cs_n, sclk);
  initial cs_n = 1'b1;
  initial sclk = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // five-cycle half period: 2.5 MHz, clock still between frames
  task automatic frame(input int nclk, output logic [15:0] w);
    w = 16'h0000;
    cs_n = 1'b0;
    tick(5);
    for (int i = 0; i < nclk; i++) begin
      sclk = 1'b0;
      tick(5);
      sclk = 1'b1;
      w = {w[14:0], dout};
      tick(5);
    end
    cs_n = 1'b1;
    tick(20);
  endtask
endmodule
`default_nettype wire

// ==== tb/dsar_readout_tb.sv ====
// self-checking bench for the sar readout
`timescale 1ns/1ps
`default_nettype none
module dsar_readout_tb;
  logic sys_clk = 1'b0, rst = 1'b1, dout, cs_n, sclk, track_q, busy_q, vld;
  logic [13:0] vin = 14'h0000, trial, res;
  logic [13:0] tv [5] = '{14'h0000, 14'h1fff, 14'h2000, 14'h3fff, 14'h1555};
  logic [15:0] w;
  int n_mismatch = 0, samples_checked = 0;
  // ideal comparator on the offset-binary trial
  wire logic cmp_above = (vin ^ 14'h2000) >= trial;
  initial forever #20 sys_clk = ~sys_clk;
  dsar_host host (.sys_clk(sys_clk), .dout(dout), .cs_n(cs_n), .sclk(sclk));
  dsar_readout dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .dout(dout),
    .cmp_above(cmp_above), .dac_trial_q(trial), .track_q(track_q), .busy_q(busy_q),
    .result_q(res), .result_valid_q(vld));
  task automatic chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_convert(input logic [13:0] v);
    vin = v;
    host.frame(16, w);
    chk(w, {2'b00, v});
    chk({2'b00, res}, {2'b00, v});
  endtask
  // early release: partial word seen, old result kept
  task automatic t_abort;
    vin = ~vin;
    host.frame(8, w);
    chk(w, {10'h000, vin[13:8]});
    chk({14'h0000, track_q, busy_q}, 16'h0002);
    chk({2'b00, res}, {2'b00, ~vin});
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk({12'h000, dout, track_q, busy_q, vld}, 16'h0004);
    foreach (tv[i]) t_convert(tv[i]);
    t_abort;
    t_convert(14'h2aaa);
    report_and_stop;
  end
endmodule
`default_nettype wire
